// ---- logic/cmp_edge_event_ctrl.sv ----
// Comparator edge-event control: input routing, edge events, flag, pin and timer output, registers
// Contract
// - Enabled comparator keeps running in wait mode
// - Stop3 keeps comparing, flags events, wakes
// - Stop3 keeps driving the output pin
// - Reset leaves every bit at reset value
// - Deep stop powers down, state reset
// - Debug halt leaves operation unaffected
// - Minus pin always; plus pin when select 0
// - Capture routing feeds timer, takes its pin
// - Event on rising, falling or either edge
// - Output pin carries result only when enabled
// - Mode field picks the edge condition
// - Flag clears only on written one
// - Output status reads live result, zero disabled
// - Interrupt while flag and enable both set
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
module cmp_edge_event_ctrl (
	input  wire logic               sys_clk,
	input  wire logic               srst,
	input  wire cmp_pkg::axilReq_t  axiReq,
	output cmp_pkg::axilRsp_t       axiRsp,
	input  wire cmp_pkg::lowPower_t lowPower,
	input  wire logic               compareRaw,
	output logic                    analogPowerOn,
	output logic                    minusInputConnect,
	output logic                    plusInputConnect,
	output logic                    referenceConnect,
	output logic                    bandgapBufferEnable,
	output logic                    compareOutputPin,
	output logic                    compareOutputPinOe,
	output logic                    timerCaptureIn,
	output logic                    timerPinDisconnect,
	output logic                    wakeRequest,
	output logic                    irq
);

	logic                       clearAll;
	logic                       wrStrobe;
	logic [cmp_pkg::ADDR_W-1:0] wrAddr;
	logic [cmp_pkg::DATA_W-1:0] wrData;
	logic [3:0]                 wrStrb;
	logic                       wrHit;
	logic                       rdStrobe;
	logic [cmp_pkg::DATA_W-1:0] rdData;
	logic                       rdHit;
	logic                       lane0Write;

	logic                       syncLevel;
	logic                       syncRise;
	logic                       syncFall;
	logic                       compareEvent;
	logic                       compareIrq;

	logic                       moduleEnable_reg;
	logic                       referenceSelect_reg;
	logic                       compareIrqEnable_reg;
	logic                       outputPinEnable_reg;
	cmp_pkg::eventMode_t        eventMode_reg;
	logic                       compareEventFlag_reg;
	logic                       outputStatus_reg;
	logic                       captureRouting_reg;
	logic                       bandgapBuffer_reg;
	logic [cmp_pkg::INT_W-1:0]  intStatus_reg;
	logic [cmp_pkg::INT_W-1:0]  intStatus_next;
	logic [cmp_pkg::INT_W-1:0]  intMask_reg;
	logic                       pinOut_reg;
	logic                       pinOe_reg;
	logic                       timerIn_reg;
	logic [7:0]                 ctrlView;

	// Bus reset and deep-stop power-down both return the block to reset state
	assign clearAll = srst | lowPower.deepStopMode;

	cmp_axil_slave busSlave (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.req      (axiReq),
		.rsp      (axiRsp),
		.wrStrobe (wrStrobe),
		.wrAddr   (wrAddr),
		.wrData   (wrData),
		.wrStrb   (wrStrb),
		.wrHit    (wrHit),
		.rdStrobe (rdStrobe),
		.rdData   (rdData),
		.rdHit    (rdHit)
	);

	cmp_edge_sync edgeSync (
		.sys_clk (sys_clk),
		.clear   (clearAll),
		.asyncIn (compareRaw),
		.level   (syncLevel),
		.rise    (syncRise),
		.fall    (syncFall)
	);

	assign lane0Write = wrStrobe & wrStrb[0] & ~lowPower.deepStopMode;

	always_comb begin
		case (wrAddr)
			cmp_pkg::OFF_CTRL, cmp_pkg::OFF_SYSOPT, cmp_pkg::OFF_PWR,
			cmp_pkg::OFF_INTSTAT, cmp_pkg::OFF_INTMASK: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
	end

	// Edge qualification; wait, stop3 and debug halt do not gate it
	always_comb begin
		case (eventMode_reg)
			cmp_pkg::MODE_RISE: compareEvent = syncRise;
			cmp_pkg::MODE_BOTH: compareEvent = syncRise | syncFall;
			cmp_pkg::MODE_FALL, cmp_pkg::MODE_FALL_ALT: compareEvent = syncFall;
			default: compareEvent = 1'b0;
		endcase
		compareEvent = compareEvent & moduleEnable_reg;
	end

	// Control bits
	always_ff @(posedge sys_clk) begin
		if (clearAll) begin
			moduleEnable_reg     <= cmp_pkg::CTRL_RESET[cmp_pkg::BIT_ENABLE];
			referenceSelect_reg  <= cmp_pkg::CTRL_RESET[cmp_pkg::BIT_REFSEL];
			compareIrqEnable_reg <= cmp_pkg::CTRL_RESET[cmp_pkg::BIT_IRQEN];
			outputPinEnable_reg  <= cmp_pkg::CTRL_RESET[cmp_pkg::BIT_PINEN];
			eventMode_reg        <= cmp_pkg::eventMode_t'(cmp_pkg::CTRL_RESET[cmp_pkg::MODE_LSB +: cmp_pkg::MODE_W]);
		end else if (lane0Write && wrAddr == cmp_pkg::OFF_CTRL) begin
			moduleEnable_reg     <= wrData[cmp_pkg::BIT_ENABLE];
			referenceSelect_reg  <= wrData[cmp_pkg::BIT_REFSEL];
			compareIrqEnable_reg <= wrData[cmp_pkg::BIT_IRQEN];
			outputPinEnable_reg  <= wrData[cmp_pkg::BIT_PINEN];
			eventMode_reg        <= cmp_pkg::eventMode_t'(wrData[cmp_pkg::MODE_LSB +: cmp_pkg::MODE_W]);
		end
	end

	// Event flag: set wins over a write-one clear
	always_ff @(posedge sys_clk) begin
		if (clearAll) begin
			compareEventFlag_reg <= cmp_pkg::CTRL_RESET[cmp_pkg::BIT_FLAG];
		end else if (compareEvent) begin
			compareEventFlag_reg <= 1'b1;
		end else if (lane0Write && wrAddr == cmp_pkg::OFF_CTRL && wrData[cmp_pkg::BIT_FLAG]) begin
			compareEventFlag_reg <= 1'b0;
		end
	end

	// Live result, forced low while disabled
	always_ff @(posedge sys_clk) begin
		if (clearAll) begin
			outputStatus_reg <= cmp_pkg::CTRL_RESET[cmp_pkg::BIT_OUTSTAT];
		end else begin
			outputStatus_reg <= moduleEnable_reg & syncLevel;
		end
	end

	// System-level option bits
	always_ff @(posedge sys_clk) begin
		if (clearAll) begin
			captureRouting_reg <= cmp_pkg::SYSOPT_RESET;
			bandgapBuffer_reg  <= cmp_pkg::PWR_RESET;
		end else if (lane0Write) begin
			if (wrAddr == cmp_pkg::OFF_SYSOPT) begin
				captureRouting_reg <= wrData[cmp_pkg::BIT_CAPROUTE];
			end
			if (wrAddr == cmp_pkg::OFF_PWR) begin
				bandgapBuffer_reg <= wrData[cmp_pkg::BIT_BGBUF];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clearAll) begin
			intMask_reg <= cmp_pkg::INTMASK_RESET;
		end else if (lane0Write && wrAddr == cmp_pkg::OFF_INTMASK) begin
			intMask_reg <= wrData[cmp_pkg::INT_W-1:0];
		end
	end

	// Sticky status, cleared by reading it; a new event in the read cycle survives
	always_comb begin
		intStatus_next = intStatus_reg;
		if (rdStrobe && axiReq.araddr == cmp_pkg::OFF_INTSTAT) begin
			intStatus_next = '0;
		end
		intStatus_next[cmp_pkg::INT_COMPARE] = intStatus_next[cmp_pkg::INT_COMPARE] | compareEvent;
		intStatus_next[cmp_pkg::INT_WAKE]    = intStatus_next[cmp_pkg::INT_WAKE] | wakeRequest;
	end

	always_ff @(posedge sys_clk) begin
		if (clearAll) begin
			intStatus_reg <= '0;
		end else begin
			intStatus_reg <= intStatus_next;
		end
	end

	// Output pin keeps working in stop3 and debug halt
	always_ff @(posedge sys_clk) begin
		if (clearAll) begin
			pinOut_reg <= 1'b0;
			pinOe_reg  <= 1'b0;
		end else begin
			pinOut_reg <= outputPinEnable_reg & moduleEnable_reg & syncLevel;
			pinOe_reg  <= outputPinEnable_reg & moduleEnable_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clearAll) begin
			timerIn_reg <= 1'b0;
		end else begin
			timerIn_reg <= captureRouting_reg & moduleEnable_reg & syncLevel;
		end
	end

	assign compareOutputPin    = pinOut_reg;
	assign compareOutputPinOe  = pinOe_reg;
	assign timerCaptureIn      = timerIn_reg;
	assign timerPinDisconnect  = captureRouting_reg;
	assign analogPowerOn       = moduleEnable_reg & ~lowPower.deepStopMode;
	assign minusInputConnect   = analogPowerOn;
	assign plusInputConnect    = analogPowerOn & ~referenceSelect_reg;
	assign referenceConnect    = analogPowerOn & referenceSelect_reg;
	assign bandgapBufferEnable = bandgapBuffer_reg;

	assign compareIrq  = compareEventFlag_reg & compareIrqEnable_reg;
	assign wakeRequest = compareIrq & (lowPower.waitMode | lowPower.stop3Mode);
	assign irq         = compareIrq | (|(intStatus_reg & intMask_reg));

	always_comb begin
		ctrlView = '0;
		ctrlView[cmp_pkg::BIT_ENABLE]  = moduleEnable_reg;
		ctrlView[cmp_pkg::BIT_REFSEL]  = referenceSelect_reg;
		ctrlView[cmp_pkg::BIT_FLAG]    = compareEventFlag_reg;
		ctrlView[cmp_pkg::BIT_IRQEN]   = compareIrqEnable_reg;
		ctrlView[cmp_pkg::BIT_OUTSTAT] = outputStatus_reg;
		ctrlView[cmp_pkg::BIT_PINEN]   = outputPinEnable_reg;
		ctrlView[cmp_pkg::MODE_LSB +: cmp_pkg::MODE_W] = eventMode_reg;
	end

	always_comb begin
		rdData = '0;
		rdHit  = 1'b1;
		case (axiReq.araddr)
			cmp_pkg::OFF_CTRL:    rdData[7:0] = ctrlView;
			cmp_pkg::OFF_SYSOPT:  rdData[cmp_pkg::BIT_CAPROUTE] = captureRouting_reg;
			cmp_pkg::OFF_PWR:     rdData[cmp_pkg::BIT_BGBUF] = bandgapBuffer_reg;
			cmp_pkg::OFF_INTSTAT: rdData[cmp_pkg::INT_W-1:0] = intStatus_reg;
			cmp_pkg::OFF_INTMASK: rdData[cmp_pkg::INT_W-1:0] = intMask_reg;
			default:              rdHit = 1'b0;
		endcase
	end

	// Checks
	logic [1:0] cleanHist_reg;

	always_ff @(posedge sys_clk) begin
		if (clearAll) begin
			cleanHist_reg <= '0;
		end else begin
			cleanHist_reg <= {cleanHist_reg[0], 1'b1};
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	AST_SYNC_DEPTH: assert property (cleanHist_reg[1] && !lowPower.deepStopMode |-> syncLevel == $past(compareRaw, 2))
		else $error("synchronised result does not trail the raw input by two edges");

	AST_EVENT_SETS_FLAG: assert property (compareEvent && !lowPower.deepStopMode |=> compareEventFlag_reg)
		else $error("compare event did not set the flag");

	AST_FALL_ONLY: assert property (moduleEnable_reg && eventMode_reg != cmp_pkg::MODE_BOTH
			&& eventMode_reg != cmp_pkg::MODE_RISE && syncRise |-> !compareEvent)
		else $error("rising edge raised an event in a falling-edge mode");

	AST_RISE_MODE: assert property (moduleEnable_reg && eventMode_reg == cmp_pkg::MODE_RISE && syncRise
			&& !lowPower.deepStopMode |=> compareEventFlag_reg)
		else $error("rising edge missed in rising mode");

	AST_ZERO_KEEPS_FLAG: assert property (compareEventFlag_reg && wrStrobe && wrAddr == cmp_pkg::OFF_CTRL
			&& !wrData[cmp_pkg::BIT_FLAG] && !lowPower.deepStopMode |=> compareEventFlag_reg)
		else $error("writing zero cleared the flag");

	AST_ONE_CLEARS_FLAG: assert property (lane0Write && wrAddr == cmp_pkg::OFF_CTRL
			&& wrData[cmp_pkg::BIT_FLAG] && !compareEvent && !lowPower.deepStopMode |=> !compareEventFlag_reg)
		else $error("writing one did not clear the flag");

	AST_STATUS_DISABLED: assert property (!moduleEnable_reg ##1 !moduleEnable_reg |-> ctrlView[cmp_pkg::BIT_OUTSTAT] == 1'b0)
		else $error("output status not zero while disabled");

	AST_IRQ_LEVEL: assert property (compareEventFlag_reg && compareIrqEnable_reg |-> irq)
		else $error("interrupt low with flag and enable set");

	AST_PIN_GATED: assert property (!(outputPinEnable_reg && moduleEnable_reg) |=> !compareOutputPinOe && !compareOutputPin)
		else $error("pin carries result while output disabled");

	AST_PIN_STOP3: assert property (lowPower.stop3Mode && outputPinEnable_reg && moduleEnable_reg
			&& !lowPower.deepStopMode |=> compareOutputPin == $past(syncLevel))
		else $error("pin stopped following result in stop3");

	AST_DEEP_STOP: assert property (lowPower.deepStopMode |=> !moduleEnable_reg && !compareEventFlag_reg && intStatus_reg == '0)
		else $error("state not at reset after deep stop");

	AST_WAIT_RUNS: assert property (moduleEnable_reg && (lowPower.waitMode || lowPower.debugHalt)
			&& !lowPower.deepStopMode |-> analogPowerOn)
		else $error("comparator halted in wait or debug");

	AST_INPUT_ROUTE: assert property (!(plusInputConnect && referenceConnect) && (!plusInputConnect || minusInputConnect))
		else $error("both non-inverting sources connected");

	AST_TIMER_ROUTE: assert property (captureRouting_reg && moduleEnable_reg && !lowPower.deepStopMode
			|=> timerCaptureIn == $past(syncLevel) && $past(timerPinDisconnect))
		else $error("timer capture input not fed by comparator");

	AST_WAKE: assert property (compareIrq && lowPower.stop3Mode |-> wakeRequest)
		else $error("no wake on event in stop3");

	AST_WAKE_WAIT: assert property (compareIrq && lowPower.waitMode |-> wakeRequest)
		else $error("no wake on event in wait mode");

	AST_PLUS_ROUTE: assert property (analogPowerOn && !referenceSelect_reg
			|-> plusInputConnect && minusInputConnect && !referenceConnect)
		else $error("plus pin not routed while reference select is clear");

	AST_STATUS_LIVE: assert property (moduleEnable_reg && !lowPower.deepStopMode
			|=> ctrlView[cmp_pkg::BIT_OUTSTAT] == $past(syncLevel))
		else $error("output status does not follow the result");

	AST_FLAG_HOLD: assert property (compareEventFlag_reg && !lane0Write && !lowPower.deepStopMode
			|=> compareEventFlag_reg)
		else $error("flag cleared without a written one");

	AST_DEBUG_RUNS: assert property (lowPower.debugHalt && moduleEnable_reg && syncFall
			&& eventMode_reg == cmp_pkg::MODE_BOTH && !lowPower.deepStopMode |=> compareEventFlag_reg)
		else $error("falling edge missed during debug halt");

	COV_BOTH_EDGES: cover property (eventMode_reg == cmp_pkg::MODE_BOTH && syncFall && compareEvent);
	COV_STOP3_WAKE: cover property (lowPower.stop3Mode && wakeRequest);
	COV_FLAG_CLEAR: cover property (compareEventFlag_reg ##1 !compareEventFlag_reg);
	COV_DEBUG_EVENT: cover property (lowPower.debugHalt && compareEvent);
	COV_DEEP_STOP: cover property (lowPower.deepStopMode && moduleEnable_reg);

endmodule // cmp_edge_event_ctrl

// ---- common/cmp_pkg.sv ----
// Shared constants, register layout and carrier types for the comparator control block
package cmp_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SYSOPT  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_PWR     = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_INTSTAT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_INTMASK = 8'h10;

	// Control and status register fields
	localparam int BIT_ENABLE  = 7;
	localparam int BIT_REFSEL  = 6;
	localparam int BIT_FLAG    = 5;
	localparam int BIT_IRQEN   = 4;
	localparam int BIT_OUTSTAT = 3;
	localparam int BIT_PINEN   = 2;
	localparam int MODE_LSB    = 0;
	localparam int MODE_W      = 2;

	localparam int BIT_CAPROUTE = 0;
	localparam int BIT_BGBUF    = 0;

	// Interrupt status and mask bits
	localparam int INT_COMPARE = 0;
	localparam int INT_WAKE    = 1;
	localparam int INT_W       = 2;

	// Values after reset
	localparam logic [7:0]       CTRL_RESET    = 8'h00;
	localparam logic             SYSOPT_RESET  = 1'h0;
	localparam logic             PWR_RESET     = 1'h0;
	localparam logic [INT_W-1:0] INTMASK_RESET = 2'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [MODE_W-1:0] {MODE_FALL, MODE_RISE, MODE_FALL_ALT, MODE_BOTH} eventMode_t;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axilReq_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} axilRsp_t;

	typedef struct packed {
		logic waitMode;
		logic stop3Mode;
		logic deepStopMode;
		logic debugHalt;
	} lowPower_t;

endpackage

// ---- logic/cmp_edge_sync.sv ----
// Two-stage synchroniser and edge detector for the raw comparator result
module cmp_edge_sync (
	input  wire logic sys_clk,
	input  wire logic clear,
	input  wire logic asyncIn,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic stage1_reg;
	logic stage2_reg;
	logic prev_reg;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (clear) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end else begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clear) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= stage2_reg;
		end
	end

	assign level = stage2_reg;
	assign rise  = stage2_reg & ~prev_reg;
	assign fall  = ~stage2_reg & prev_reg;

endmodule // cmp_edge_sync

// ---- logic/cmp_axil_slave.sv ----
// AXI4-Lite slave front end: one write and one read under way at a time
module cmp_axil_slave (
	input  wire logic                       sys_clk,
	input  wire logic                       srst,
	input  wire cmp_pkg::axilReq_t          req,
	output cmp_pkg::axilRsp_t               rsp,
	output logic                            wrStrobe,
	output logic [cmp_pkg::ADDR_W-1:0]      wrAddr,
	output logic [cmp_pkg::DATA_W-1:0]      wrData,
	output logic [3:0]                      wrStrb,
	input  wire logic                       wrHit,
	output logic                            rdStrobe,
	input  wire logic [cmp_pkg::DATA_W-1:0] rdData,
	input  wire logic                       rdHit
);

	logic                       awHeld_reg;
	logic                       wHeld_reg;
	logic                       bvalid_reg;
	logic [1:0]                 bresp_reg;
	logic                       rvalid_reg;
	logic [cmp_pkg::DATA_W-1:0] rdata_reg;
	logic [1:0]                 rresp_reg;

	assign rsp.awready = ~awHeld_reg & ~bvalid_reg;
	assign rsp.wready  = ~wHeld_reg & ~bvalid_reg;
	assign rsp.arready = ~rvalid_reg;
	assign rsp.bvalid  = bvalid_reg;
	assign rsp.bresp   = bresp_reg;
	assign rsp.rvalid  = rvalid_reg;
	assign rsp.rdata   = rdata_reg;
	assign rsp.rresp   = rresp_reg;

	assign wrStrobe = awHeld_reg & wHeld_reg & ~bvalid_reg;
	assign rdStrobe = req.arvalid & ~rvalid_reg;

	// Address and data may arrive in either order
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
			wrAddr     <= '0;
			wrData     <= '0;
			wrStrb     <= '0;
		end else if (wrStrobe) begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
		end else begin
			if (req.awvalid && rsp.awready) begin
				awHeld_reg <= 1'b1;
				wrAddr     <= req.awaddr;
			end
			if (req.wvalid && rsp.wready) begin
				wHeld_reg <= 1'b1;
				wrData    <= req.wdata;
				wrStrb    <= req.wstrb;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= cmp_pkg::RESP_OKAY;
		end else if (wrStrobe) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wrHit ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_SLVERR;
		end else if (req.bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= cmp_pkg::RESP_OKAY;
		end else if (rdStrobe) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rdHit ? rdData : '0;
			rresp_reg  <= rdHit ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_SLVERR;
		end else if (req.rready) begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule // cmp_axil_slave

// ---- bench/analog_front_model.sv ----
// Behavioural analog comparator front end feeding the raw compare result
module analog_front_model (
	input  wire logic        analogPowerOn,
	input  wire logic        minusInputConnect,
	input  wire logic        plusInputConnect,
	input  wire logic        referenceConnect,
	input  wire logic [15:0] plusMv,
	input  wire logic [15:0] minusMv,
	input  wire logic [15:0] bandgapMv,
	output logic             compareRaw
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] nonInv;

	// An unpowered or unconnected comparator gives a low result
	always_comb begin
		nonInv = referenceConnect ? bandgapMv : plusMv;
		compareRaw = analogPowerOn & minusInputConnect & (plusInputConnect | referenceConnect) & (nonInv > minusMv);
	end
endmodule // analog_front_model

// ---- bench/testbench.sv ----
// Self-checking bench for the comparator edge-event control block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic               sys_clk;
	logic               srst;
	cmp_pkg::axilReq_t  req;
	cmp_pkg::axilRsp_t  rsp;
	cmp_pkg::lowPower_t lowPower;
	logic               compareRaw, analogPowerOn, minusInputConnect, plusInputConnect, referenceConnect;
	logic               bandgapBufferEnable, compareOutputPin, compareOutputPinOe, timerCaptureIn;
	logic               timerPinDisconnect, wakeRequest, irq;
	logic [15:0]        plusMv, minusMv, bandgapMv;
	logic [31:0]        rdVal;
	logic [1:0]         resp;
	int                 miscompares, tests_run, cycles;
	logic               rise, fall;

	cmp_edge_event_ctrl dut_u (.sys_clk, .srst, .axiReq(req), .axiRsp(rsp), .lowPower, .compareRaw,
		.analogPowerOn, .minusInputConnect, .plusInputConnect, .referenceConnect, .bandgapBufferEnable,
		.compareOutputPin, .compareOutputPinOe, .timerCaptureIn, .timerPinDisconnect, .wakeRequest, .irq);

	analog_front_model front_u (.analogPowerOn, .minusInputConnect, .plusInputConnect, .referenceConnect,
		.plusMv, .minusMv, .bandgapMv, .compareRaw);

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Handshakes are judged at the falling edge, where every level is settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		do begin
			@(negedge sys_clk);
			aw = req.awvalid & rsp.awready;
			w = req.wvalid & rsp.wready;
			b = rsp.bvalid;
			resp = rsp.bresp;
			@(posedge sys_clk);
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
		end while (!b);
	endtask

	task automatic rd(input logic [7:0] a);
		logic ar, r;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		do begin
			@(negedge sys_clk);
			ar = req.arvalid & rsp.arready;
			r = rsp.rvalid;
			rdVal = rsp.rdata;
			resp = rsp.rresp;
			@(posedge sys_clk);
			if (ar) req.arvalid <= 1'b0;
		end while (!r);
	endtask

	// Raw change reaches the flag within three edges
	task automatic setPlus(input logic [15:0] v);
		plusMv <= v;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic testReset();
		for (int i = 0; i < 5; i++) begin
			rd(8'(i * 4));
			chk("reset value", rdVal, 32'h0);
		end
		rd(8'h14);
		chk("unmapped read", {30'h0, resp}, {30'h0, cmp_pkg::RESP_SLVERR});
		wr(8'h14, 32'hff);
		chk("unmapped write", {30'h0, resp}, {30'h0, cmp_pkg::RESP_SLVERR});
		@(negedge sys_clk);
		chk("power", analogPowerOn, 1'b0);
		chk("irq", irq, 1'b0);
		@(posedge sys_clk);
		$display("reset test done");
	endtask

	task automatic testModes();
		for (int m = 0; m < 4; m++) begin
			rise = (m == 1) || (m == 3);
			fall = (m != 1);
			wr(cmp_pkg::OFF_CTRL, 32'h90 | m);
			setPlus(16'h0100);
			wr(cmp_pkg::OFF_CTRL, 32'hb0 | m);
			rd(cmp_pkg::OFF_CTRL);
			chk("idle ctrl", rdVal, 32'h90 | m);
			setPlus(16'h0500);
			rd(cmp_pkg::OFF_CTRL);
			chk("rise flag", rdVal, 32'h98 | m | (rise ? 32'h20 : 32'h0));
			@(negedge sys_clk);
			chk("irq", irq, rise);
			@(posedge sys_clk);
			wr(cmp_pkg::OFF_CTRL, 32'hb0 | m);
			setPlus(16'h0100);
			rd(cmp_pkg::OFF_CTRL);
			chk("fall flag", rdVal, 32'h90 | m | (fall ? 32'h20 : 32'h0));
			wr(cmp_pkg::OFF_CTRL, 32'h90 | m);
			rd(cmp_pkg::OFF_CTRL);
			chk("flag kept", rdVal, 32'h90 | m | (fall ? 32'h20 : 32'h0));
			wr(cmp_pkg::OFF_CTRL, 32'hb0 | m);
			rd(cmp_pkg::OFF_CTRL);
			chk("flag cleared", rdVal, 32'h90 | m);
		end
		$display("edge mode test done");
	endtask

	task automatic testPins();
		wr(cmp_pkg::OFF_CTRL, 32'h83);
		setPlus(16'h0500);
		@(negedge sys_clk);
		chk("pin oe", compareOutputPinOe, 1'b0);
		chk("pin data", compareOutputPin, 1'b0);
		chk("plus link", plusInputConnect, 1'b1);
		chk("minus link", minusInputConnect, 1'b1);
		chk("ref link", referenceConnect, 1'b0);
		@(posedge sys_clk);
		lowPower.stop3Mode <= 1'b1;
		lowPower.debugHalt <= 1'b1;
		wr(cmp_pkg::OFF_CTRL, 32'h87);
		setPlus(16'h0500);
		@(negedge sys_clk);
		chk("pin oe", compareOutputPinOe, 1'b1);
		chk("pin data", compareOutputPin, 1'b1);
		@(posedge sys_clk);
		setPlus(16'h0100);
		@(negedge sys_clk);
		chk("pin data", compareOutputPin, 1'b0);
		@(posedge sys_clk);
		wr(cmp_pkg::OFF_SYSOPT, 32'h1);
		setPlus(16'h0500);
		@(negedge sys_clk);
		chk("timer pin", timerPinDisconnect, 1'b1);
		chk("capture", timerCaptureIn, 1'b1);
		@(posedge sys_clk);
		lowPower <= '0;
		wr(cmp_pkg::OFF_CTRL, 32'h20);
		rd(cmp_pkg::OFF_CTRL);
		chk("status off", rdVal, 32'h0);
		wr(cmp_pkg::OFF_PWR, 32'h1);
		plusMv <= 16'h0100;
		wr(cmp_pkg::OFF_CTRL, 32'hc0);
		setPlus(16'h0100);
		rd(cmp_pkg::OFF_CTRL);
		chk("bandgap status", rdVal, 32'hc8);
		@(negedge sys_clk);
		chk("buffer", bandgapBufferEnable, 1'b1);
		chk("ref link", referenceConnect, 1'b1);
		chk("plus link", plusInputConnect, 1'b0);
		@(posedge sys_clk);
		$display("pin test done");
	endtask

	task automatic testIrq();
		wr(cmp_pkg::OFF_CTRL, 32'h93);
		setPlus(16'h0100);
		wr(cmp_pkg::OFF_CTRL, 32'hb3);
		rd(cmp_pkg::OFF_INTSTAT);
		lowPower.waitMode <= 1'b1;
		setPlus(16'h0500);
		@(negedge sys_clk);
		chk("wake", wakeRequest, 1'b1);
		chk("irq", irq, 1'b1);
		@(posedge sys_clk);
		rd(cmp_pkg::OFF_INTSTAT);
		chk("sticky", rdVal[0], 1'b1);
		rd(cmp_pkg::OFF_INTSTAT);
		chk("read clears", rdVal[0], 1'b0);
		lowPower <= '0;
		wr(cmp_pkg::OFF_CTRL, 32'ha3);
		wr(cmp_pkg::OFF_INTMASK, 32'h1);
		setPlus(16'h0100);
		@(negedge sys_clk);
		chk("masked irq", irq, 1'b1);
		@(posedge sys_clk);
		rd(cmp_pkg::OFF_INTSTAT);
		@(negedge sys_clk);
		chk("irq cleared", irq, 1'b0);
		@(posedge sys_clk);
		wr(cmp_pkg::OFF_INTMASK, 32'h0);
		lowPower.stop3Mode <= 1'b1;
		wr(cmp_pkg::OFF_CTRL, 32'hb3);
		setPlus(16'h0500);
		@(negedge sys_clk);
		chk("stop wake", wakeRequest, 1'b1);
		@(posedge sys_clk);
		rd(cmp_pkg::OFF_CTRL);
		chk("stop flag", rdVal, 32'hbb);
		lowPower <= '0;
		$display("interrupt test done");
	endtask

	task automatic testDeep();
		wr(cmp_pkg::OFF_CTRL, 32'h97);
		lowPower.deepStopMode <= 1'b1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("power", analogPowerOn, 1'b0);
		@(posedge sys_clk);
		lowPower.deepStopMode <= 1'b0;
		rd(cmp_pkg::OFF_CTRL);
		chk("deep ctrl", rdVal, 32'h0);
		chk("pin oe", compareOutputPinOe, 1'b0);
		wr(cmp_pkg::OFF_CTRL, 32'h97);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rd(cmp_pkg::OFF_CTRL);
		chk("reset ctrl", rdVal, 32'h0);
		rd(cmp_pkg::OFF_PWR);
		chk("reset pwr", rdVal, 32'h0);
		$display("deep stop test done");
	endtask

	initial begin
		sys_clk = 1'b0;
		srst = 1'b1;
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		lowPower = '0;
		plusMv = 16'h0100;
		minusMv = 16'h0300;
		bandgapMv = 16'h0500;
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		testReset();
		testModes();
		testPins();
		testIrq();
		testDeep();
		conclude();
	end
endmodule // testbench
